// >>> qrfr_pkg.sv
// Constants and carriers for the frequency reduction and soft-start core
// Summary of operation
// - Supply turn-on stops charging cell, starts soft-start
// - Soft-start lasts 12ms in 4 equal steps
// - Peak limit steps from 0.32V up to 1V
// - Counter holds zero crossings to skip
// - Evaluate feedback every 48ms, update at end
// - Always below count-up threshold: increment, max 7
// - Above count-up, never count-down: hold value
// - Above count-down, never reset: decrement, min 1
// - Above counter-reset threshold: force counter to 1
// - Counter always stays within 1 to 7
// - Counter loads 1 at start-up
// - Count-up and count-down thresholds shift with sensed line voltage; the counter-reset threshold does not
// - Switch-on allowed when crossings reach counter
package qrfr_pkg;
	localparam int CLK_MHZ = 100;
	localparam int SOFT_START_MS = 12;
	localparam int SOFT_STEPS = 4;
	localparam int STEP_CYCLES = SOFT_START_MS * 1000 * CLK_MHZ / SOFT_STEPS;
	localparam int EVAL_PERIOD_MS = 48;
	localparam int EVAL_CYCLES = EVAL_PERIOD_MS * 1000 * CLK_MHZ;
	localparam logic [2:0] CNT_MIN = 3'h1;
	localparam logic [2:0] CNT_MAX = 3'h7;
	localparam logic [2:0] CNT_RESET = 3'h1;
	// Peak limit codes 0..4: 0.32V, stepped levels, 1V final
	localparam logic [2:0] LIMIT_FIRST = 3'h0;
	localparam logic [2:0] LIMIT_FINAL = 3'h4;
	typedef enum logic [2:0] {
		QRFR_OFF = 3'h1,
		QRFR_SOFT = 3'h2,
		QRFR_RUN = 3'h4
	} qrfr_state_e;
	// Feedback comparator results
	typedef struct packed {
		logic aboveReset;
		logic aboveDown;
		logic aboveUp;
	} qrfr_fb_s;
endpackage

// >>> qrfr_eval.sv
// Sticky feedback flags and up/down counter update
`timescale 1ns/1ps
module qrfr_eval #(
	parameter int PERIOD_CYCLES = qrfr_pkg::EVAL_CYCLES
) (
	// Clock and control
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	// Synchronised comparators
	input wire qrfr_pkg::qrfr_fb_s fb,
	// Counter
	output logic [2:0] count_r,
	output logic periodEnd
);
	logic [31:0] perCnt_r;
	qrfr_pkg::qrfr_fb_s sticky_r;
	qrfr_pkg::qrfr_fb_s seen;

	assign periodEnd = run && (perCnt_r == 32'(PERIOD_CYCLES - 1));
	// Include this cycle's sample so the last cycle is not lost
	assign seen = sticky_r | fb;

	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			perCnt_r <= 32'h0;
		end else if (periodEnd) begin
			perCnt_r <= 32'h0;
		end else begin
			perCnt_r <= perCnt_r + 32'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !run || periodEnd) begin
			sticky_r <= '0;
		end else begin
			sticky_r <= seen;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			count_r <= qrfr_pkg::CNT_RESET;
		end else if (periodEnd) begin
			if (seen.aboveReset) begin
				count_r <= qrfr_pkg::CNT_RESET;
			end else if (seen.aboveDown) begin
				if (count_r != qrfr_pkg::CNT_MIN) begin
					count_r <= count_r - 3'h1;
				end
			end else if (!seen.aboveUp) begin
				if (count_r != qrfr_pkg::CNT_MAX) begin
					count_r <= count_r + 3'h1;
				end
			end
		end
	end

	property p_range;
		@(posedge clk) disable iff (!rst_n)
		count_r >= qrfr_pkg::CNT_MIN && count_r <= qrfr_pkg::CNT_MAX;
	endproperty
	a_range: assert property (p_range) else $error("Counter out of range");
	property p_resetForce;
		@(posedge clk) disable iff (!rst_n)
		(periodEnd && seen.aboveReset) |=> count_r == qrfr_pkg::CNT_RESET;
	endproperty
	a_resetForce: assert property (p_resetForce) else $error("No force to 1");
	property p_up;
		@(posedge clk) disable iff (!rst_n)
		(periodEnd && seen == '0 && count_r != 3'h7)
			|=> count_r == $past(count_r) + 3'h1;
	endproperty
	a_up: assert property (p_up) else $error("No increment");
	property p_hold;
		@(posedge clk) disable iff (!rst_n)
		(periodEnd && seen.aboveUp && !seen.aboveDown && !seen.aboveReset)
			|=> $stable(count_r);
	endproperty
	a_hold: assert property (p_hold) else $error("Counter moved on hold");
	property p_down;
		@(posedge clk) disable iff (!rst_n)
		(periodEnd && seen.aboveDown && !seen.aboveReset && count_r != 3'h1)
			|=> count_r == $past(count_r) - 3'h1;
	endproperty
	a_down: assert property (p_down) else $error("No decrement");
	property p_quiet;
		@(posedge clk) disable iff (!rst_n)
		(run && !periodEnd) |=> $stable(count_r) || !$past(run);
	endproperty
	a_quiet: assert property (p_quiet) else $error("Update off boundary");
	property p_clear;
		@(posedge clk) disable iff (!rst_n)
		periodEnd |=> sticky_r == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("Flags not cleared");
endmodule

// >>> qrfr_core.sv
// Soft-start sequencer, threshold selection and switch-on permit
`timescale 1ns/1ps
module qrfr_core #(
	parameter int STEP_CYCLES = qrfr_pkg::STEP_CYCLES,
	parameter int PERIOD_CYCLES = qrfr_pkg::EVAL_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Analog inputs, asynchronous
	input wire logic supplyOn,
	input wire logic fbAboveUpLow,
	input wire logic fbAboveDownLow,
	input wire logic fbAboveUpHigh,
	input wire logic fbAboveDownHigh,
	input wire logic fbAboveReset,
	input wire logic lineHigh,
	// Switch-on stage, same clock
	input wire logic ringDone,
	input wire logic [2:0] zeroCrossCount,
	// Outputs
	output logic startCellOff_r,
	output logic switchEnable_r,
	output logic [2:0] peakLimit_r,
	output logic [2:0] skipCount_r,
	output logic gateOnPermit_r
);
	logic [1:0] sSup_r, sUpL_r, sDnL_r, sUpH_r, sDnH_r, sRst_r, sLine_r;
	qrfr_pkg::qrfr_state_e state_r;
	logic [31:0] stepCnt_r;
	logic [2:0] count;
	logic running;
	qrfr_pkg::qrfr_fb_s fb;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sSup_r <= 2'h0;
			sUpL_r <= 2'h0;
			sDnL_r <= 2'h0;
			sUpH_r <= 2'h0;
			sDnH_r <= 2'h0;
			sRst_r <= 2'h0;
			sLine_r <= 2'h0;
		end else begin
			sSup_r <= {sSup_r[0], supplyOn};
			sUpL_r <= {sUpL_r[0], fbAboveUpLow};
			sDnL_r <= {sDnL_r[0], fbAboveDownLow};
			sUpH_r <= {sUpH_r[0], fbAboveUpHigh};
			sDnH_r <= {sDnH_r[0], fbAboveDownHigh};
			sRst_r <= {sRst_r[0], fbAboveReset};
			sLine_r <= {sLine_r[0], lineHigh};
		end
	end

	// Line level picks the comparator pair so limit foldback cannot move them
	always_comb begin
		fb.aboveReset = sRst_r[1];
		fb.aboveUp = sLine_r[1] ? sUpH_r[1] : sUpL_r[1];
		fb.aboveDown = sLine_r[1] ? sDnH_r[1] : sDnL_r[1];
	end

	assign running = state_r != qrfr_pkg::QRFR_OFF;

	// Supply drop returns to off; next turn-on restarts soft-start
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= qrfr_pkg::QRFR_OFF;
			stepCnt_r <= 32'h0;
			peakLimit_r <= qrfr_pkg::LIMIT_FIRST;
		end else if (!sSup_r[1]) begin
			state_r <= qrfr_pkg::QRFR_OFF;
			stepCnt_r <= 32'h0;
			peakLimit_r <= qrfr_pkg::LIMIT_FIRST;
		end else begin
			unique case (state_r)
				qrfr_pkg::QRFR_OFF: begin
					state_r <= qrfr_pkg::QRFR_SOFT;
				end
				qrfr_pkg::QRFR_SOFT: begin
					if (stepCnt_r == 32'(STEP_CYCLES - 1)) begin
						stepCnt_r <= 32'h0;
						if (peakLimit_r == qrfr_pkg::LIMIT_FINAL - 3'h1) begin
							state_r <= qrfr_pkg::QRFR_RUN;
						end
						peakLimit_r <= peakLimit_r + 3'h1;
					end else begin
						stepCnt_r <= stepCnt_r + 32'h1;
					end
				end
				qrfr_pkg::QRFR_RUN: begin
					peakLimit_r <= qrfr_pkg::LIMIT_FINAL;
				end
				default: begin
					state_r <= qrfr_pkg::QRFR_OFF;
				end
			endcase
		end
	end

	qrfr_eval #(
		.PERIOD_CYCLES(PERIOD_CYCLES)
	) u_eval (
		.clk(clk),
		.rst_n(rst_n),
		.run(running),
		.fb(fb),
		.count_r(count),
		.periodEnd()
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			startCellOff_r <= 1'b0;
			switchEnable_r <= 1'b0;
			skipCount_r <= qrfr_pkg::CNT_RESET;
			gateOnPermit_r <= 1'b0;
		end else begin
			startCellOff_r <= running;
			switchEnable_r <= running;
			skipCount_r <= count;
			gateOnPermit_r <= running && ringDone && zeroCrossCount >= count;
		end
	end

	// Supply loss drops the limit, so only while still powered
	property p_limitFinal;
		@(posedge clk) disable iff (!rst_n)
		(state_r == qrfr_pkg::QRFR_RUN && sSup_r[1])
			|=> peakLimit_r == qrfr_pkg::LIMIT_FINAL;
	endproperty
	a_limitFinal: assert property (p_limitFinal) else $error("Final limit");
	property p_limitMono;
		@(posedge clk) disable iff (!rst_n)
		(sSup_r[1] && $past(sSup_r[1]) && state_r != qrfr_pkg::QRFR_OFF)
			|-> peakLimit_r >= $past(peakLimit_r);
	endproperty
	a_limitMono: assert property (p_limitMono) else $error("Limit fell");
	sequence s_turnOn;
		!running ##1 running;
	endsequence
	property p_cellOff;
		@(posedge clk) disable iff (!rst_n)
		s_turnOn |=> startCellOff_r && switchEnable_r;
	endproperty
	a_cellOff: assert property (p_cellOff) else $error("Cell not off");
	property p_permit;
		@(posedge clk) disable iff (!rst_n)
		gateOnPermit_r |-> $past(zeroCrossCount) >= $past(count);
	endproperty
	a_permit: assert property (p_permit) else $error("Early permit");
	property p_startCnt;
		@(posedge clk) disable iff (!rst_n)
		s_turnOn |-> count == qrfr_pkg::CNT_RESET;
	endproperty
	a_startCnt: assert property (p_startCnt) else $error("Start count");
endmodule

// >>> qrfr_analog_model.sv
// Comparator bank model driven by a feedback level code
`timescale 1ns/1ps
module qrfr_analog_model (
	// Feedback level and line sense
	input wire logic [1:0] level,
	input wire logic lineHigh,
	// Comparator outputs
	output logic upLow,
	output logic downLow,
	output logic upHigh,
	output logic downHigh,
	output logic aboveReset
);
	qrfr_pkg::qrfr_fb_s fb;
	assign fb = {level == 2'h3, level >= 2'h2, level >= 2'h1};
	// Unused set reads inverted, so a wrong pick is seen
	assign upLow = lineHigh ? !fb.aboveUp : fb.aboveUp;
	assign downLow = lineHigh ? !fb.aboveDown : fb.aboveDown;
	assign upHigh = lineHigh ? fb.aboveUp : !fb.aboveUp;
	assign downHigh = lineHigh ? fb.aboveDown : !fb.aboveDown;
	assign aboveReset = fb.aboveReset;
endmodule

// >>> qr_freq_reduction_softstart_bench.sv
// Self-checking bench for the soft-start and counter core
`timescale 1ns/1ps
module qr_freq_reduction_softstart_bench;
	localparam int STEP = 10;
	localparam int PER = 50;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic supplyOn = 1'b0;
	logic lineHigh = 1'b0;
	logic ringDone = 1'b0;
	logic [2:0] zc = 3'h0;
	logic [1:0] level = 2'h0;
	logic upL, dnL, upH, dnH, rstC, cellOff, swEn, permit;
	logic [2:0] limit, skip;
	logic [15:0] lfsr = 16'h7733;
	int nErrors = 0;
	int checkCount = 0;
	always #5 clk = !clk;
	qrfr_analog_model u_model (.level(level), .lineHigh(lineHigh),
		.upLow(upL), .downLow(dnL), .upHigh(upH), .downHigh(dnH),
		.aboveReset(rstC));
	qrfr_core #(.STEP_CYCLES(STEP), .PERIOD_CYCLES(PER)) u_dut (
		.clk(clk), .rst_n(rst_n), .supplyOn(supplyOn),
		.fbAboveUpLow(upL), .fbAboveDownLow(dnL), .fbAboveUpHigh(upH),
		.fbAboveDownHigh(dnH), .fbAboveReset(rstC), .lineHigh(lineHigh),
		.ringDone(ringDone), .zeroCrossCount(zc),
		.startCellOff_r(cellOff), .switchEnable_r(swEn),
		.peakLimit_r(limit), .skipCount_r(skip), .gateOnPermit_r(permit));
	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// Expected counter after one period at the highest level seen
	function automatic logic [2:0] upd(input logic [2:0] c,
		input logic [1:0] l);
		case (l)
			2'h0: return (c == 3'h7) ? c : c + 3'h1;
			2'h1: return c;
			2'h2: return (c == 3'h1) ? c : c - 3'h1;
			default: return 3'h1;
		endcase
	endfunction
	task automatic chk(input string what, input logic [2:0] e,
		input logic [2:0] g);
		checkCount++;
		if (g !== e) begin
			nErrors++;
			$display("wrong value %s expected %0h seen %0h", what, e, g);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", checkCount, nErrors);
		if (nErrors == 0 && checkCount > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	logic prevRd = 1'b0;
	logic [2:0] prevZc = 3'h0;
	logic prevRun = 1'b0;
	// Counter copy lags the internal one, so compare with the new copy
	always @(negedge clk) begin
		if (prevRun && limit === 3'h4) begin
			chk("permit", {2'h0, prevRd && prevZc >= skip}, {2'h0, permit});
		end
		lfsr = nxt(lfsr);
		ringDone = lfsr[0];
		zc = lfsr[3:1];
		prevRd = ringDone;
		prevZc = zc;
		prevRun = (limit === 3'h4) && (swEn === 1'b1);
	end
	initial begin
		int t;
		logic [2:0] e;
		logic [1:0] lv;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		chk("skip", 3'h1, skip);
		chk("cell", 3'h0, {2'h0, cellOff});
		supplyOn = 1'b1;
		repeat (3) @(negedge clk);
		chk("cell", 3'h0, {2'h0, cellOff});
		@(negedge clk);
		chk("enable", 3'h1, {2'h0, swEn});
		chk("cell", 3'h1, {2'h0, cellOff});
		chk("limit", 3'h0, limit);
		for (int s = 1; s <= 4; s++) begin
			t = 0;
			while (limit === 3'(s - 1) && t < 3 * STEP) begin
				@(negedge clk);
				t++;
			end
			chk("limit", 3'(s), limit);
			if (s > 1) begin
				chk("step length", 3'h0, (t == STEP) ? 3'h0 : 3'h1);
			end
		end
		// Periods run from turn-on; soft-start is shorter than one
		// period, so its quiet period has already counted up once
		e = 3'h2;
		repeat (PER / 2) @(negedge clk);
		chk("skip", e, skip);
		// Levels change mid-period so each period spans two of them
		for (int k = 0; k < 30; k++) begin
			lv = (k < 8) ? 2'h0 : (k < 16) ? 2'h2 : (k == 16) ? 2'h1 : lfsr[5:4];
			e = upd(e, (lv > level) ? lv : level);
			level = lv;
			lineHigh = lfsr[7];
			repeat (PER - 10) @(negedge clk);
			chk("skip", e, skip);
			repeat (10) @(negedge clk);
		end
		supplyOn = 1'b0;
		t = 0;
		while (cellOff === 1'b1 && t < 10) begin
			@(negedge clk);
			t++;
		end
		@(negedge clk);
		chk("cell", 3'h0, {2'h0, cellOff});
		chk("enable", 3'h0, {2'h0, swEn});
		chk("skip", 3'h1, skip);
		summarize();
	end
	initial begin
		// About two and a half times the length of a clean run
		#40000;
		nErrors++;
		summarize();
	end
endmodule
